// File: core/acf_alu_flags.sv
/*
 * acf_alu_flags: ALU condition flag register of the core with its ALU,
 * an instruction execution port and an APB slave for software access.
 * Assumes instruction requests come from logic on clk_in, one per cycle.
 */
// Local design decisions: the APB register port and the register addresses.
//
// Contract
// - flags live in one register usable as any instruction's operand
// - flag-affecting instruction aimed at flags drops result, updates flags only
// - wiping the flag register sets zero flag, keeps other flags
// - in subtraction carry flags mean inverted borrow and digit borrow
// - wrap flag set when signed result changes sign bit, else clear
// - low-half flag updated by both adds and both subtracts
// - low-half flag is the carry out of bit 3
// - carry flag is the carry out of bit 7
`timescale 1ns/1ns
`default_nettype none
`include "acf_params.svh"

module acf_alu_flags (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // apb slave
    input wire acf_pkg::acf_apb_req_t apb_req_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // instruction execution
    input wire acf_pkg::acf_instr_t instr_in,
    output logic [7:0] result_out,
    output logic result_we_out,
    output logic [7:0] flags_out
);

    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
        addr_hit = (addr == off);
    endfunction

    logic rst_meta_q;
    logic rst_n_q;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] result_q;
    logic [7:0] result_d;
    logic result_we_q;
    logic result_we_d;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // apb decode; answers one cycle into the access phase
    wire apb_access = apb_req_in.psel & apb_req_in.penable & ~pready_q;
    wire hit_flags = addr_hit(apb_req_in.paddr, `ACF_OFF_FLAGS);
    wire hit_result = addr_hit(apb_req_in.paddr, `ACF_OFF_RESULT);
    // a flag register write commits on the completing edge, while the master still holds it
    wire apb_flags_wr = apb_req_in.psel & apb_req_in.penable & pready_q &
                        apb_req_in.pwrite & hit_flags;

    assign pready_d = apb_access;
    assign pslverr_d = apb_access & ~hit_flags & ~hit_result;
    assign prdata_d = !apb_access ? prdata_q :
                      hit_flags ? {24'h000000, flags_q} :
                      hit_result ? {24'h000000, result_q} : 32'h00000000;

    // instruction side
    wire instr_fire = instr_in.valid;
    wire [7:0] calc_result;
    wire [4:0] calc_flags;
    wire [4:0] calc_mask;

    acf_flag_calc u_calc (
        .op_in(instr_in.op),
        .file_in(instr_in.file_val),
        .work_in(instr_in.work_val),
        .literal_in(instr_in.literal),
        .bit_sel_in(instr_in.bit_sel),
        .result_out(calc_result),
        .flags_new_out(calc_flags),
        .flags_mask_out(calc_mask)
    );

    wire flag_touch = instr_fire & (|calc_mask);
    wire to_flags = instr_fire & instr_in.dest_is_flags;
    // a non-flag operation aimed at the register stores its result there
    wire store_into_flags = to_flags & ~(|calc_mask);

    // per flag: the instruction's own update or stored result wins; any flag update drops the whole software write
    genvar gi;
    generate
        for (gi = 0; gi < `ACF_FLAG_W; gi = gi + 1) begin : g_flag
            assign flags_d[gi] = (flag_touch && calc_mask[gi]) ? calc_flags[gi] :
                                 store_into_flags ? calc_result[gi] :
                                 (apb_flags_wr && !flag_touch) ? apb_req_in.pwdata[gi] :
                                 flags_q[gi];
        end
    endgenerate
    assign flags_d[7:`ACF_FLAG_W] = 3'b000;

    // result is dropped whenever the flag register was the destination
    assign result_we_d = instr_fire & ~instr_in.dest_is_flags;
    assign result_d = instr_fire ? calc_result : result_q;

    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
            flags_q <= `ACF_FLAGS_RST;
            result_q <= `ACF_RESULT_RST;
            result_we_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            flags_q <= flags_d;
            result_q <= result_d;
            result_we_q <= result_we_d;
        end
    end

    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign prdata_out = prdata_q;
    assign flags_out = flags_q;
    assign result_out = result_q;
    assign result_we_out = result_we_q;

endmodule
`default_nettype wire

// File: core/acf_params.svh
/*
 * acf_params.svh: register offsets, flag bit positions, reset values and
 * field widths of the ALU condition flag block.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef ACF_PARAMS_SVH
`define ACF_PARAMS_SVH

// register byte offsets on the APB
`define ACF_OFF_FLAGS 12'h000
`define ACF_OFF_RESULT 12'h004

// flag bit positions inside the flag register
`define ACF_BIT_CARRY 0
`define ACF_BIT_HALF 1
`define ACF_BIT_ZERO 2
`define ACF_BIT_WRAP 3
`define ACF_BIT_SIGN 4

// number of implemented flag bits; bits above read as zero
`define ACF_FLAG_W 5

// reset values
`define ACF_FLAGS_RST 8'h00
`define ACF_RESULT_RST 8'h00

// flag groups touched by each class of operation
`define ACF_MASK_ARITH 5'h1F
`define ACF_MASK_LOGIC 5'h14
`define ACF_MASK_WIPE 5'h04
`define ACF_MASK_NONE 5'h00

`endif

// File: core/acf_pkg.sv
/*
 * acf_pkg: types of the ALU condition flag block: operation codes, the
 * instruction request carrier and the APB request carrier.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acf_pkg;

    typedef enum logic [3:0] {
        acf_nop_op,
        add_work_file_op,
        add_literal_op,
        literal_minus_work_op,
        file_minus_work_op,
        acf_and_op,
        acf_or_op,
        acf_xor_op,
        wipe_register_op,
        bit_set_op,
        bit_reset_op,
        nibble_exchange_op,
        file_to_file_copy_op,
        work_to_file_copy_op
    } acf_op_t;

    typedef struct packed {
        logic valid;
        acf_op_t op;
        logic [7:0] file_val;
        logic [7:0] work_val;
        logic [7:0] literal;
        logic [2:0] bit_sel;
        logic dest_is_flags;
    } acf_instr_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } acf_apb_req_t;

endpackage

// File: core/acf_flag_calc.sv
/*
 * acf_flag_calc: combinational ALU for one instruction; gives the result,
 * the new flag values and the mask of flags the operation touches.
 * Assumes operands are stable for the whole cycle in which they are used.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acf_params.svh"

module acf_flag_calc (
    // operation
    input wire acf_pkg::acf_op_t op_in,
    input wire logic [7:0] file_in,
    input wire logic [7:0] work_in,
    input wire logic [7:0] literal_in,
    input wire logic [2:0] bit_sel_in,
    // answer
    output logic [7:0] result_out,
    output logic [4:0] flags_new_out,
    output logic [4:0] flags_mask_out
);

    logic [7:0] add_x;
    logic [7:0] add_y;
    logic add_cin;
    logic [8:0] sum_full;
    logic [4:0] sum_low;
    logic is_arith;
    logic [7:0] bit_onehot;

    // subtraction adds the inverted subtrahend plus one, so both carries
    // come out as inverted borrows: set means no borrow happened
    assign add_x = (op_in == acf_pkg::add_literal_op ||
                    op_in == acf_pkg::literal_minus_work_op) ? literal_in : file_in;
    assign add_cin = (op_in == acf_pkg::literal_minus_work_op ||
                      op_in == acf_pkg::file_minus_work_op);
    assign add_y = add_cin ? ~work_in : work_in;
    assign sum_full = {1'b0, add_x} + {1'b0, add_y} + {8'h00, add_cin};
    assign sum_low = {1'b0, add_x[3:0]} + {1'b0, add_y[3:0]} + {4'h0, add_cin};
    assign is_arith = (op_in == acf_pkg::add_work_file_op) ||
                      (op_in == acf_pkg::add_literal_op) || add_cin;
    assign bit_onehot = 8'h01 << bit_sel_in;

    always_comb begin
        result_out = file_in;
        flags_mask_out = `ACF_MASK_NONE;
        case (op_in)
            acf_pkg::add_work_file_op,
            acf_pkg::add_literal_op,
            acf_pkg::literal_minus_work_op,
            acf_pkg::file_minus_work_op: begin
                result_out = sum_full[7:0];
                flags_mask_out = `ACF_MASK_ARITH;
            end
            acf_pkg::acf_and_op: begin
                result_out = file_in & work_in;
                flags_mask_out = `ACF_MASK_LOGIC;
            end
            acf_pkg::acf_or_op: begin
                result_out = file_in | work_in;
                flags_mask_out = `ACF_MASK_LOGIC;
            end
            acf_pkg::acf_xor_op: begin
                result_out = file_in ^ work_in;
                flags_mask_out = `ACF_MASK_LOGIC;
            end
            acf_pkg::wipe_register_op: begin
                result_out = 8'h00;
                flags_mask_out = `ACF_MASK_WIPE;
            end
            acf_pkg::bit_set_op: result_out = file_in | bit_onehot;
            acf_pkg::bit_reset_op: result_out = file_in & ~bit_onehot;
            acf_pkg::nibble_exchange_op: result_out = {file_in[3:0], file_in[7:4]};
            acf_pkg::file_to_file_copy_op: result_out = file_in;
            acf_pkg::work_to_file_copy_op: result_out = work_in;
            default: result_out = file_in;
        endcase
    end

    always_comb begin
        flags_new_out = 5'h00;
        flags_new_out[`ACF_BIT_SIGN] = result_out[7];
        flags_new_out[`ACF_BIT_ZERO] = (result_out == 8'h00);
        flags_new_out[`ACF_BIT_CARRY] = is_arith & sum_full[8];
        flags_new_out[`ACF_BIT_HALF] = is_arith & sum_low[4];
        // like-signed operands giving a result of the other sign
        flags_new_out[`ACF_BIT_WRAP] = is_arith & (add_x[7] == add_y[7]) &
                                       (sum_full[7] != add_x[7]);
    end

endmodule
`default_nettype wire

// File: verif/acf_alu_flags_props.sv
/* acf_alu_flags_props: flag and write-back checks on the flag block ports.
   Assumes one clock domain and binding to acf_alu_flags. */
`timescale 1ns/1ns
`default_nettype none
module acf_alu_flags_props (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // apb
    input wire acf_pkg::acf_apb_req_t apb_req_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // instruction
    input wire acf_pkg::acf_instr_t instr_in,
    input wire logic [7:0] result_out,
    input wire logic result_we_out,
    input wire logic [7:0] flags_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    wire [7:0] f_w = instr_in.file_val;
    wire [7:0] w_w = instr_in.work_val;
    wire [8:0] sum_w = {1'b0, f_w} + {1'b0, w_w};
    wire [8:0] dif_w = {1'b0, f_w} + {1'b0, ~w_w} + 9'h001;
    wire [4:0] half_w = {1'b0, f_w[3:0]} + {1'b0, w_w[3:0]};
    wire wrap_w = f_w[7] == w_w[7] && sum_w[7] != f_w[7];
    sequence s_add;
        instr_in.valid && instr_in.op == acf_pkg::add_work_file_op && !instr_in.dest_is_flags;
    endsequence
    sequence s_sub;
        instr_in.valid && instr_in.op == acf_pkg::file_minus_work_op;
    endsequence
    sequence s_wipe;
        instr_in.valid && instr_in.op == acf_pkg::wipe_register_op && instr_in.dest_is_flags;
    endsequence
    a_upper_zero: assert property (flags_out[7:5] == 3'h0)
        else $error("upper flag bits set");
    a_add_carry: assert property (s_add |=> flags_out[0] == $past(sum_w[8]))
        else $error("add carry wrong");
    a_add_half: assert property (s_add |=> flags_out[1] == $past(half_w[4]))
        else $error("add half carry wrong");
    a_add_wrap: assert property (s_add |=> flags_out[3] == $past(wrap_w))
        else $error("wrap flag wrong");
    a_sign_copy: assert property (s_add |=> flags_out[4] == $past(sum_w[7]))
        else $error("sign flag wrong");
    a_sub_borrow: assert property (s_sub |=> flags_out[0] == $past(dif_w[8]))
        else $error("borrow wrong");
    a_zero_flag: assert property (s_sub |=> flags_out[2] == ($past(dif_w[7:0]) == 8'h00))
        else $error("zero flag wrong");
    a_wipe_keep: assert property (s_wipe |=> flags_out == ($past(flags_out) | 8'h04))
        else $error("wipe changed other flags");
    a_write_back: assert property (instr_in.valid && !instr_in.dest_is_flags |=> result_we_out)
        else $error("missing write back");
    a_flags_dest: assert property (instr_in.valid && instr_in.dest_is_flags |=> !result_we_out)
        else $error("result written");
endmodule
bind acf_alu_flags acf_alu_flags_props chk_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .apb_req_in(apb_req_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .instr_in(instr_in), .result_out(result_out),
    .result_we_out(result_we_out), .flags_out(flags_out));
`default_nettype wire

// File: verif/acf_alu_flags_tb_top.sv
/* acf_alu_flags_tb_top: directed bench over APB and the instruction port.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ns
`default_nettype none
module acf_alu_flags_tb_top;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    acf_pkg::acf_apb_req_t req = '0;
    acf_pkg::acf_instr_t ins = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, we, err;
    logic [7:0] res, flg;
    int failures = 0;
    int check_count = 0;
    acf_pkg::acf_op_t ops [4] = '{acf_pkg::add_work_file_op, acf_pkg::add_literal_op,
        acf_pkg::literal_minus_work_op, acf_pkg::file_minus_work_op};
    logic [15:0] vec [5] = '{16'h7F01, 16'hFF01, 16'h0001, 16'h0505, 16'h8080};
    always #4 clk_in = ~clk_in;
    acf_alu_flags dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .apb_req_in(req),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .instr_in(ins),
        .result_out(res), .result_we_out(we), .flags_out(flg));
    // subtraction as f + ~w + 1, so carries read as inverted borrows
    function automatic logic [15:0] calc(input logic [7:0] f, w, input logic sub);
        logic [7:0] b;
        logic [8:0] s;
        logic [4:0] h;
        b = sub ? ~w : w;
        s = {1'b0, f} + {1'b0, b} + {8'h00, sub};
        h = {1'b0, f[3:0]} + {1'b0, b[3:0]} + {4'h0, sub};
        return {s[7:0], 3'h0, s[7], f[7] == b[7] && s[7] != f[7], s[7:0] == 8'h00, h[4], s[8]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic exec(input acf_pkg::acf_op_t op, input logic [7:0] f, w, input logic d);
        @(posedge clk_in);
        ins <= '{1'b1, op, f, w, f, w[2:0], d};
        @(posedge clk_in);
        ins.valid <= 1'b0;
        // the write strobe stands for this one cycle only
        @(negedge clk_in);
    endtask
    // request held until pready is seen high at a rising edge; the watchdog cuts a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_in);
        req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge clk_in);
        req.penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1) @(posedge clk_in);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        foreach (ops[i]) foreach (vec[j]) begin
            exec(ops[i], vec[j][15:8], vec[j][7:0], 1'b0);
            chk({res, flg}, calc(vec[j][15:8], vec[j][7:0], i >= 2));
            chk(we, 1'b1);
        end
        $display("test arith done");
        apb(1'b1, 12'h000, 32'hFFFF_FFFF);
        exec(acf_pkg::add_work_file_op, 8'h7F, 8'h01, 1'b1);
        chk({flg, 7'h0, we}, 16'h1A00);
        apb(1'b1, 12'h000, 32'h0000_0013);
        exec(acf_pkg::wipe_register_op, 8'h55, 8'h00, 1'b1);
        chk({flg, 7'h0, we}, 16'h1700);
        exec(acf_pkg::bit_set_op, flg, 8'h03, 1'b1);
        chk(flg, 8'h1F);
        exec(acf_pkg::nibble_exchange_op, 8'h12, 8'h00, 1'b0);
        chk({res, flg}, 16'h211F);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h1F);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test dest done");
        exec(acf_pkg::acf_and_op, 8'hF0, 8'h0F, 1'b0);
        chk({res, flg}, 16'h000F);
        exec(acf_pkg::acf_xor_op, 8'hF0, 8'h0F, 1'b0);
        chk({res, flg}, 16'hFF1B);
        exec(acf_pkg::bit_reset_op, 8'hFF, 8'h07, 1'b0);
        chk({res, flg}, 16'h7F1B);
        exec(acf_pkg::work_to_file_copy_op, 8'h3C, 8'h00, 1'b0);
        chk({res, flg}, 16'h001B);
        exec(acf_pkg::file_to_file_copy_op, 8'h3C, 8'h00, 1'b0);
        chk({res, flg}, 16'h3C1B);
        apb(1'b1, 12'h004, 32'h0000_00AA);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h3C);
        $display("test misc done");
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk({res, flg, 7'h0, we}, 24'h0);
        exec(acf_pkg::add_work_file_op, 8'h00, 8'h00, 1'b0);
        chk({res, flg}, 16'h0004);
        $display("test reset done");
        end_sim();
    end
endmodule
`default_nettype wire
